// ==== lane_mapper.sv ====
// sample-to-lane mapper and serializer test pattern source, two links
//
// Overview of operation
// - 8-lane single channel: even samples to link A, odd to link B.
// - 16-lane single channel: S0..S14 even on A lanes, odd on B.
// - 8-lane dual channel: A samples 0-3 on link A, B on link B.
// - 16-lane dual channel: A samples 0-7 on link A, B on link B.
// - 4-lane modes: two lanes per link, same split as above.
// - 64b/66b sync header is CRC-12 or FEC only, chosen by register.
// - power-down pin high disables every serial output driver.
// - lane count follows the link configuration whatever the pattern.
// - prbs bypasses transport and link layers; each lane own phase.
// - prbs7: new bit is xor of bits six and seven back.
// - prbs9: new bit is xor of bits five and nine back.
// - prbs15, prbs23, prbs31 use taps 14/15, 18/23, 28/31.
// - clock pattern: eight ones, eight zeros, bypassing the layers.
// - ramp: identical counting octet on all lanes, formatter ignored.
// - ramp starts after ILAS in 8b/10b, after serdes init in 64b/66b.
// - short transport: lane k sends k, then 0xff minus k.
// - alternating-bits mode sends endless D21.5 in both encodings.
// - comma mode sends endless K28.5, 8b/10b only.
// - repeated ILAS: sync request starts CGS, then ILAS forever.
// - random jitter pattern repeats twelve octets, 8b/10b only.
// - those twelve octets are 0xbe, 0xd7 ... 0x59 in order.
// - samples are offset binary octets sent msb first.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module lane_mapper #(
  parameter int LANES = 8
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  input  wire logic [lane_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         power_down_pin,
  input  wire logic                         frame_tick,
  input  wire logic [16*LANES-1:0]          sample_in,
  input  wire logic                         ilas_done,
  input  wire logic                         serdes_init_done,
  input  wire logic                         sync_request_n,
  output logic      [8*LANES-1:0]           link_a_lanes,
  output logic      [8*LANES-1:0]           link_b_lanes,
  output logic                              lanes_valid,
  output logic      [2*LANES-1:0]           lane_driver_en,
  output logic      [2*LANES-1:0]           lane_ctrl_char,
  output logic                              layer_bypass,
  output logic                              ilas_repeat,
  output logic                              cgs_request,
  output logic                              sync_header_fec
);
  import lane_pkg::*;

  typedef struct packed {
    logic                 link_en;
    logic                 sh_fec;
    logic [6:0]           cfg;
    tp_t                  tp;
    logic                 frame_odd;
    logic [7:0]           ramp;
    logic                 ramp_go;
    logic [3:0]           random_jitter_pattern_idx;
    logic [8*LANES-1:0]   a;
    logic [8*LANES-1:0]   b;
    logic [2*LANES-1:0]   drv_en;
    logic [2*LANES-1:0]   kchar;
    logic                 bypass;
    logic                 valid;
    logic                 ilas_rep;
    logic                 cgs_req;
    logic [31:0]          rdata;
  } st_t;

  st_t q;
  st_t d;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  logic [3:0] lanes;
  logic       dual;
  logic       enc64;
  logic       cfg_ok;
  logic       tp_bad;

  always_comb begin
    lanes  = 4'd0;
    dual   = 1'b0;
    enc64  = 1'b0;
    cfg_ok = 1'b1;
    case (q.cfg)
      MODE_S8_8B: lanes = 4'd4;
      MODE_S16_8B: lanes = 4'd8;
      MODE_D8_8B: begin lanes = 4'd4; dual = 1'b1; end
      MODE_D16_8B: begin lanes = 4'd8; dual = 1'b1; end
      MODE_S4_64B: begin lanes = 4'd2; enc64 = 1'b1; end
      MODE_D4_64B: begin
        lanes = 4'd2;
        dual  = 1'b1;
        enc64 = 1'b1;
      end
      MODE_S8_64B: begin lanes = 4'd4; enc64 = 1'b1; end
      MODE_D8_64B: begin
        lanes = 4'd4;
        dual  = 1'b1;
        enc64 = 1'b1;
      end
      MODE_S16_64B: begin lanes = 4'd8; enc64 = 1'b1; end
      MODE_D16_64B: begin
        lanes = 4'd8;
        dual  = 1'b1;
        enc64 = 1'b1;
      end
      default: cfg_ok = 1'b0;
    endcase
  end

  // comma, repeated ILAS and jitter pattern have no 64b/66b form
  assign tp_bad = enc64 && (q.tp == TP_K285 || q.tp == TP_ILAS_REP ||
                            q.tp == TP_RANDOM_JITTER_PATTERN);

  // ---------------------------------------------------------------
  // per-lane octet selection
  // ---------------------------------------------------------------
  function automatic logic [7:0] pick(input tp_t        tp,
                                      input logic       bad,
                                      input logic [7:0] norm,
                                      input logic [7:0] prbs,
                                      input logic [7:0] shortp,
                                      input logic [7:0] ramp,
                                      input logic [7:0] random_jitter_pattern,
                                      input logic       odd);
    if (bad) begin
      pick = 8'h00;
    end else begin
      case (tp)
        TP_NORMAL: pick = norm;
        TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23, TP_PRBS31:
          pick = prbs;
        TP_CLOCK: pick = odd ? 8'h00 : OCT_ONES;
        TP_RAMP: pick = ramp;
        TP_SHORT: pick = shortp;
        TP_D215: pick = OCT_D215;
        TP_K285: pick = OCT_K285;
        TP_ILAS_REP: pick = norm;
        TP_RANDOM_JITTER_PATTERN: pick = random_jitter_pattern;
        default: pick = norm;
      endcase
    end
  endfunction

  logic [8*LANES-1:0] oct_a;
  logic [8*LANES-1:0] oct_b;
  logic [2*LANES-1:0] en_w;
  logic               adv;
  logic [7:0]         random_jitter_pattern_w;

  assign adv    = frame_tick && q.link_en;
  assign random_jitter_pattern_w = random_jitter_pattern_octet(q.random_jitter_pattern_idx);

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      localparam logic [7:0] LI = 8'(i);
      logic [7:0] norm_a;
      logic [7:0] norm_b;
      logic [7:0] short_w;
      prbs_if pa ();
      prbs_if pb ();

      // single channel interleaves even/odd; dual keeps channels apart
      assign norm_a = dual ? sample_in[8*i +: 8]
                           : sample_in[16*i +: 8];
      assign norm_b = dual ? sample_in[8*LANES + 8*i +: 8]
                           : sample_in[16*i + 8 +: 8];
      assign short_w = q.frame_odd ? (OCT_ONES - LI) : LI;

      assign pa.advance = adv;
      assign pa.sel     = q.tp;
      assign pb.advance = adv;
      assign pb.sel     = q.tp;

      prbs_lane_gen #(.LANE(i)) u_prbs_a (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .p       (pa.gen)
      );
      prbs_lane_gen #(.LANE(i + LANES)) u_prbs_b (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .p       (pb.gen)
      );

      assign oct_a[8*i +: 8] = pick(q.tp, tp_bad, norm_a, pa.data,
                                    short_w, q.ramp, random_jitter_pattern_w, q.frame_odd);
      assign oct_b[8*i +: 8] = pick(q.tp, tp_bad, norm_b, pb.data,
                                    short_w, q.ramp, random_jitter_pattern_w, q.frame_odd);
      // lowest lanes only; the rest stay powered down
      assign en_w[i]         = (4'(i) < lanes);
      assign en_w[i + LANES] = (4'(i) < lanes);
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb access
  // ---------------------------------------------------------------
  logic addr_ok;
  logic setup;
  logic wr;
  logic ramp_start;

  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_CONFIG) ||
                   (paddr == ADDR_STATUS);
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite && addr_ok;
  assign pready  = clk_en;
  assign pslverr = psel && penable && !addr_ok;
  assign ramp_start = enc64 ? serdes_init_done : ilas_done;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;

    if (setup) begin
      d.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: begin
          d.rdata[CTRL_LINK_EN_BIT] = q.link_en;
          d.rdata[CTRL_FEC_BIT]     = q.sh_fec;
        end
        ADDR_CONFIG: begin
          d.rdata[CFG_SEL_LSB +: 7] = q.cfg;
          d.rdata[CFG_TP_LSB +: 4]  = q.tp;
        end
        ADDR_STATUS: begin
          d.rdata[ST_CFG_OK_BIT]    = cfg_ok;
          d.rdata[ST_RAMP_GO_BIT]   = q.ramp_go;
          d.rdata[ST_PD_BIT]        = power_down_pin;
          d.rdata[ST_TP_BAD_BIT]    = tp_bad;
          d.rdata[ST_LANES_LSB +: 4] = lanes;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    if (wr && paddr == ADDR_CTRL) begin
      d.link_en = pwdata[CTRL_LINK_EN_BIT];
      d.sh_fec  = pwdata[CTRL_FEC_BIT];
    end
    // a live link never sees its configuration or pattern move
    if (wr && paddr == ADDR_CONFIG && !q.link_en) begin
      d.cfg = pwdata[CFG_SEL_LSB +: 7];
      d.tp  = tp_t'(pwdata[CFG_TP_LSB +: 4]);
    end

    // ramp waits for the link layer to finish its start-up
    if (!q.link_en) begin
      d.ramp_go = 1'b0;
    end else if (ramp_start) begin
      d.ramp_go = 1'b1;
    end

    if (!q.link_en) begin
      d.frame_odd = 1'b0;
      d.ramp      = 8'h00;
      d.random_jitter_pattern_idx  = 4'h0;
    end else if (frame_tick) begin
      d.frame_odd = !q.frame_odd;
      if (q.ramp_go) begin
        d.ramp = q.ramp + 8'h01;
      end
      d.random_jitter_pattern_idx = (q.random_jitter_pattern_idx == RANDOM_JITTER_PATTERN_LAST) ? 4'h0
                                             : q.random_jitter_pattern_idx + 4'h1;
    end

    d.valid = frame_tick && q.link_en && cfg_ok && !power_down_pin &&
              (q.tp != TP_RAMP || q.ramp_go);
    if (frame_tick) begin
      d.a = oct_a;
      d.b = oct_b;
    end
    d.kchar  = (q.tp == TP_K285 && !tp_bad) ? '1 : '0;
    d.bypass = (q.tp == TP_CLOCK) || (q.tp == TP_PRBS7) ||
               (q.tp == TP_PRBS9) || (q.tp == TP_PRBS15) ||
               (q.tp == TP_PRBS23) || (q.tp == TP_PRBS31);
    d.drv_en = cfg_ok ? en_w : '0;

    // drivers off and data cleared while powered down
    if (power_down_pin) begin
      d.drv_en = '0;
      d.a      = '0;
      d.b      = '0;
    end

    d.ilas_rep = q.link_en && !enc64 && q.tp == TP_ILAS_REP;
    d.cgs_req  = q.link_en && !enc64 && !sync_request_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{link_en: LINK_EN_RST, sh_fec: FEC_RST, cfg: CFG_SEL_RST,
             tp: TP_NORMAL, default: '0};
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata          = q.rdata;
  assign link_a_lanes    = q.a;
  assign link_b_lanes    = q.b;
  assign lanes_valid     = q.valid;
  assign lane_driver_en  = q.drv_en;
  assign lane_ctrl_char  = q.kchar;
  assign layer_bypass    = q.bypass;
  assign ilas_repeat     = q.ilas_rep;
  assign cgs_request     = q.cgs_req;
  assign sync_header_fec = q.sh_fec;

endmodule // lane_mapper

// ==== lane_mapper_sva.sv ====
// port-level assertion checker for the lane mapper
`timescale 1ns/1ps
module lane_mapper_sva #(
  parameter int LANES = 8
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               clk_en,
  input wire logic               frame_tick,
  input wire logic               power_down_pin,
  input wire logic               sync_request_n,
  input wire logic [8*LANES-1:0] link_a_lanes,
  input wire logic [8*LANES-1:0] link_b_lanes,
  input wire logic               lanes_valid,
  input wire logic [2*LANES-1:0] lane_driver_en,
  input wire logic [2*LANES-1:0] lane_ctrl_char,
  input wire logic               layer_bypass,
  input wire logic               cgs_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pd_drivers_off: assert property (
    power_down_pin && clk_en |=> lane_driver_en == '0)
    else $error("lane drivers on during power down");
  a_pd_lanes_zero: assert property (
    power_down_pin && clk_en |=> !lanes_valid && link_a_lanes == '0
      && link_b_lanes == '0)
    else $error("lane data during power down");
  a_valid_from_tick: assert property (
    lanes_valid |-> $past(frame_tick))
    else $error("frame valid without a frame tick");
  a_valid_one_pulse: assert property (
    lanes_valid && !frame_tick |=> !lanes_valid)
    else $error("frame valid longer than one cycle");
  a_lanes_hold: assert property (
    lanes_valid && !frame_tick && !power_down_pin |=>
      $stable(link_a_lanes) && $stable(link_b_lanes))
    else $error("lane octets changed between frames");
  a_cgs_follows: assert property (
    cgs_request |-> $past(!sync_request_n))
    else $error("sync start without receiver request");
  a_bypass_no_ctrl: assert property (
    layer_bypass |-> lane_ctrl_char == '0)
    else $error("control characters in bypassed pattern");
  a_links_same_lanes: assert property (
    lanes_valid |-> lane_driver_en[0]
      && lane_driver_en[LANES-1:0] == lane_driver_en[2*LANES-1:LANES])
    else $error("links run unequal lane counts");
endmodule // lane_mapper_sva

bind lane_mapper lane_mapper_sva #(.LANES(LANES)) sva_u (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .frame_tick(frame_tick),
  .power_down_pin(power_down_pin), .sync_request_n(sync_request_n),
  .link_a_lanes(link_a_lanes), .link_b_lanes(link_b_lanes),
  .lanes_valid(lanes_valid), .lane_driver_en(lane_driver_en),
  .lane_ctrl_char(lane_ctrl_char), .layer_bypass(layer_bypass),
  .cgs_request(cgs_request));

// ==== lane_pkg.sv ====
// shared constants, types and register layout of the lane mapper block
package lane_pkg;

  // ---------------------------------------------------------------
  // register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_CONFIG      = 12'h004;
  localparam logic [11:0] ADDR_STATUS      = 12'h008;

  localparam int          CTRL_LINK_EN_BIT = 0;
  localparam int          CTRL_FEC_BIT     = 1;
  localparam int          CFG_SEL_LSB      = 0;
  localparam int          CFG_TP_LSB       = 8;
  localparam int          ST_CFG_OK_BIT    = 0;
  localparam int          ST_RAMP_GO_BIT   = 1;
  localparam int          ST_PD_BIT        = 2;
  localparam int          ST_TP_BAD_BIT    = 3;
  localparam int          ST_LANES_LSB     = 8;

  localparam logic [6:0]  CFG_SEL_RST      = 7'h05;
  localparam logic        LINK_EN_RST      = 1'b0;
  localparam logic        FEC_RST          = 1'b0;

  // ---------------------------------------------------------------
  // link configurations
  // ---------------------------------------------------------------
  localparam logic [6:0]  MODE_S8_8B       = 7'h05;
  localparam logic [6:0]  MODE_S16_8B      = 7'h06;
  localparam logic [6:0]  MODE_D8_8B       = 7'h07;
  localparam logic [6:0]  MODE_D16_8B      = 7'h08;
  localparam logic [6:0]  MODE_S4_64B      = 7'h22;
  localparam logic [6:0]  MODE_D4_64B      = 7'h23;
  localparam logic [6:0]  MODE_S8_64B      = 7'h2c;
  localparam logic [6:0]  MODE_D8_64B      = 7'h2d;
  localparam logic [6:0]  MODE_S16_64B     = 7'h32;
  localparam logic [6:0]  MODE_D16_64B     = 7'h33;

  // ---------------------------------------------------------------
  // test patterns
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TP_NORMAL   = 4'h0,
    TP_PRBS7    = 4'h1,
    TP_PRBS9    = 4'h2,
    TP_PRBS15   = 4'h3,
    TP_PRBS23   = 4'h4,
    TP_PRBS31   = 4'h5,
    TP_CLOCK    = 4'h6,
    TP_RAMP     = 4'h7,
    TP_SHORT    = 4'h8,
    TP_D215     = 4'h9,
    TP_K285     = 4'ha,
    TP_ILAS_REP = 4'hb,
    TP_RANDOM_JITTER_PATTERN     = 4'hc
  } tp_t;

  localparam logic [7:0]  OCT_D215         = 8'hb5;
  localparam logic [7:0]  OCT_K285         = 8'hbc;
  localparam logic [7:0]  OCT_ONES         = 8'hff;
  localparam logic [3:0]  RANDOM_JITTER_PATTERN_LAST        = 4'hb;
  localparam int          PRBS_W           = 31;

  function automatic logic [7:0] random_jitter_pattern_octet(input logic [3:0] idx);
    case (idx)
      4'h0:    random_jitter_pattern_octet = 8'hbe;
      4'h1:    random_jitter_pattern_octet = 8'hd7;
      4'h2:    random_jitter_pattern_octet = 8'h23;
      4'h3:    random_jitter_pattern_octet = 8'h47;
      4'h4:    random_jitter_pattern_octet = 8'h6b;
      4'h5:    random_jitter_pattern_octet = 8'h8f;
      4'h6:    random_jitter_pattern_octet = 8'hb3;
      4'h7:    random_jitter_pattern_octet = 8'h14;
      4'h8:    random_jitter_pattern_octet = 8'h5e;
      4'h9:    random_jitter_pattern_octet = 8'hfb;
      4'ha:    random_jitter_pattern_octet = 8'h35;
      4'hb:    random_jitter_pattern_octet = 8'h59;
      default: random_jitter_pattern_octet = 8'h00;
    endcase
  endfunction

endpackage

// ==== prbs_if.sv ====
// carrier between the lane mapper and one per-lane prbs generator
`timescale 1ns/1ps
interface prbs_if;
  import lane_pkg::*;
  logic       advance;
  tp_t        sel;
  logic [7:0] data;

  modport gen  (input advance, input sel, output data);
  modport user (output advance, output sel, input data);
endinterface

// ==== prbs_lane_gen.sv ====
// per-lane prbs generator, eight bits per frame, msb first
`timescale 1ns/1ps
module prbs_lane_gen #(
  parameter int LANE = 0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  prbs_if.gen       p
);
  import lane_pkg::*;

  // distinct seed per lane gives each lane its own phase
  localparam logic [PRBS_W-1:0] SEED = PRBS_W'(LANE + 1);

  typedef struct packed {
    logic [PRBS_W-1:0] hist;
    logic [7:0]        out;
  } st_t;

  st_t q;
  st_t d;

  always_comb begin
    int ta;
    int tb;
    logic nb;
    logic [PRBS_W-1:0] s;
    logic [PRBS_W-1:0] mask;
    ta = 6;
    tb = 7;
    nb = 1'b0;
    s = '0;
    mask = '0;
    d = q;
    case (p.sel)
      TP_PRBS7: begin ta = 6; tb = 7; end
      TP_PRBS9: begin ta = 5; tb = 9; end
      TP_PRBS15: begin ta = 14; tb = 15; end
      TP_PRBS23: begin ta = 18; tb = 23; end
      TP_PRBS31: begin ta = 28; tb = 31; end
      default: begin ta = 6; tb = 7; end
    endcase
    mask = PRBS_W'((64'h1 << tb) - 64'h1);
    // an all-zero window would lock the sequence at zero
    s = ((q.hist & mask) == '0) ? SEED : q.hist;
    if (p.advance) begin
      for (int k = 0; k < 8; k++) begin
        nb = s[ta-1] ^ s[tb-1];
        d.out[7-k] = nb;
        s = {s[PRBS_W-2:0], nb};
      end
      d.hist = s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{hist: SEED, out: 8'h00};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign p.data = d.out;

endmodule // prbs_lane_gen

// ==== rx_model.sv ====
// receiver-side model: sync requests and frame acceptance
`timescale 1ns/1ps
module rx_model #(
  parameter int FLUSH = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        want_sync,
  input  wire logic        power_down_pin,
  input  wire logic        lanes_valid,
  output logic             sync_request_n,
  output logic [15:0]      accepted
);
  logic [3:0] drop_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_request_n <= 1'b1;
      drop_q <= '0;
      accepted <= '0;
    end else begin
      sync_request_n <= !want_sync;
      // stale pipeline contents after power down are thrown away
      if (power_down_pin)
        drop_q <= 4'(FLUSH);
      else if (lanes_valid && drop_q != 4'h0)
        drop_q <= drop_q - 4'h1;
      else if (lanes_valid)
        accepted <= accepted + 16'h1;
    end
  end
endmodule // rx_model

// ==== serial_lane_mapper_and_test_patterns_bench.sv ====
// self-checking bench for the lane mapper
`timescale 1ns/1ps
module serial_lane_mapper_and_test_patterns_bench;
  import lane_pkg::*;
  logic         pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rq;
  logic         pready, pslverr, re, power_down_pin, frame_tick, want_sync;
  logic [127:0] sample_in;
  logic         ilas_done, serdes_init_done, sync_request_n, lanes_valid;
  logic [63:0]  link_a_lanes, link_b_lanes;
  logic [15:0]  lane_driver_en, lane_ctrl_char, accepted;
  logic         layer_bypass, ilas_repeat, cgs_request, sync_header_fec;
  int           err_count, num_checks;

  lane_mapper #(.LANES(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_pin(power_down_pin), .frame_tick(frame_tick),
    .sample_in(sample_in), .ilas_done(ilas_done),
    .serdes_init_done(serdes_init_done), .sync_request_n(sync_request_n),
    .link_a_lanes(link_a_lanes), .link_b_lanes(link_b_lanes),
    .lanes_valid(lanes_valid), .lane_driver_en(lane_driver_en),
    .lane_ctrl_char(lane_ctrl_char), .layer_bypass(layer_bypass),
    .ilas_repeat(ilas_repeat), .cgs_request(cgs_request),
    .sync_header_fec(sync_header_fec));

  rx_model #(.FLUSH(4)) rx_u (
    .pclk(pclk), .presetn(presetn), .want_sync(want_sync),
    .power_down_pin(power_down_pin), .lanes_valid(lanes_valid),
    .sync_request_n(sync_request_n), .accepted(accepted));

  always #12.5 pclk = ~pclk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic cfg(input logic [6:0] md, input tp_t tp);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CONFIG, {20'h0, tp, 1'b0, md});
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
  endtask

  task automatic frame();
    @(posedge pclk);
    frame_tick <= 1'b1;
    @(posedge pclk);
    frame_tick <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rq, 32'h5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rq[11:8], 4'h4);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    apb(1'b0, 12'h00c, 32'h0);
    chk({re, rq}, {1'b1, 32'h0});
    apb(1'b1, ADDR_CTRL, 32'h3);
    chk(sync_header_fec, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    chk(sync_header_fec, 1'b0);
    apb(1'b1, ADDR_CONFIG, 32'h7);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rq, 32'h5);
  endtask

  task automatic t_map();
    logic [6:0] md [10] = '{MODE_S8_8B, MODE_S16_8B, MODE_D8_8B, MODE_D16_8B,
      MODE_S4_64B, MODE_D4_64B, MODE_S8_64B, MODE_D8_64B, MODE_S16_64B,
      MODE_D16_64B};
    int         ln [10] = '{4, 8, 4, 8, 2, 2, 4, 4, 8, 8};
    logic [9:0] sgl = 10'b0101010011;
    logic [7:0] msk, ea, eb;
    for (int m = 0; m < 10; m++) begin
      cfg(md[m], TP_NORMAL);
      frame();
      msk = 8'((9'h1 << ln[m]) - 9'h1);
      chk(lanes_valid, 1'b1);
      chk(lane_driver_en, {msk, msk});
      for (int i = 0; i < ln[m]; i++) begin
        ea = sgl[m] ? sample_in[16*i +: 8] : sample_in[8*i +: 8];
        eb = sgl[m] ? sample_in[16*i+8 +: 8] : sample_in[64+8*i +: 8];
        chk(link_a_lanes[8*i +: 8], ea);
        chk(link_b_lanes[8*i +: 8], eb);
      end
    end
  endtask

  task automatic t_pat();
    tp_t        tp [6] = '{TP_CLOCK, TP_SHORT, TP_D215, TP_K285, TP_RANDOM_JITTER_PATTERN,
      TP_RAMP};
    logic [7:0] rp [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f, 8'hb3,
      8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
    logic [7:0] ea, eb;
    for (int p = 0; p < 6; p++) begin
      cfg(MODE_S8_8B, tp[p]);
      for (int f = 0; f < 14; f++) begin
        frame();
        eb = 8'h0;
        case (tp[p])
          TP_CLOCK: ea = f[0] ? 8'h00 : 8'hff;
          TP_SHORT: begin
            ea = f[0] ? 8'hff : 8'h00;
            eb = f[0] ? 8'hfc : 8'h03;
          end
          TP_D215: ea = 8'hb5;
          TP_K285: ea = 8'hbc;
          TP_RANDOM_JITTER_PATTERN: ea = rp[f % 12];
          default: ea = f[7:0];
        endcase
        if (tp[p] != TP_SHORT)
          eb = ea;
        chk(lanes_valid, 1'b1);
        chk(link_a_lanes[7:0], ea);
        chk(link_b_lanes[31:24], eb);
      end
      chk(layer_bypass, tp[p] == TP_CLOCK);
      if (tp[p] == TP_K285)
        chk(lane_ctrl_char, 16'hffff);
    end
    ilas_done <= 1'b0;
    cfg(MODE_S8_8B, TP_RAMP);
    frame();
    chk(lanes_valid, 1'b0);
    ilas_done <= 1'b1;
    cfg(MODE_S8_64B, TP_K285);
    frame();
    chk(link_a_lanes[7:0], 8'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rq[3], 1'b1);
  endtask

  task automatic t_prbs();
    tp_t         tp [5] = '{TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23,
      TP_PRBS31};
    int          ta [5] = '{6, 5, 14, 18, 28};
    int          tb [5] = '{7, 9, 15, 23, 31};
    logic [63:0] s, s1;
    int          bad;
    for (int p = 0; p < 5; p++) begin
      cfg(MODE_S8_8B, tp[p]);
      bad = 0;
      for (int f = 0; f < 9; f++) begin
        frame();
        s = {s[55:0], link_a_lanes[7:0]};
        s1 = {s1[55:0], link_a_lanes[15:8]};
      end
      for (int n = tb[p]; n < 64; n++)
        if (s[63-n] !== (s[63-n+ta[p]] ^ s[63-n+tb[p]]))
          bad++;
      chk(bad, 0);
      chk({layer_bypass, s == s1}, 2'b10);
    end
  endtask

  task automatic t_pd_ilas();
    logic [15:0] acc;
    cfg(MODE_S8_8B, TP_NORMAL);
    @(posedge pclk);
    power_down_pin <= 1'b1;
    frame();
    chk({lanes_valid, lane_driver_en}, '0);
    chk(link_a_lanes, '0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rq[2], 1'b1);
    power_down_pin <= 1'b0;
    acc = accepted;
    repeat (6) frame();
    #30;
    chk(accepted - acc, 16'h2);
    cfg(MODE_S8_8B, TP_ILAS_REP);
    chk(ilas_repeat, 1'b1);
    want_sync <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(cgs_request, 1'b1);
    want_sync <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk(cgs_request, 1'b0);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(25ns * 30000);
    err_count++;
    $display("Error %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, power_down_pin} = '0;
    {frame_tick, want_sync, paddr, pwdata} = '0;
    {clk_en, ilas_done, serdes_init_done} = 3'b111;
    err_count = 0;
    num_checks = 0;
    for (int n = 0; n < 16; n++)
      sample_in[8*n +: 8] = {4'(n), ~4'(n)};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_map();
    t_pat();
    t_prbs();
    t_pd_ilas();
    conclude();
  end
endmodule // serial_lane_mapper_and_test_patterns_bench
